// ===== logic/lir_reporter.sv
/*
  Link incident reporter: recognises incidents, stores records and
  delivers them to registrants as request payload words; also answers
  incoming incident report requests with accept or reject.
  Assumes framing, registration handling and the link sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
module lir_reporter
    import lir_pkg::*;
#(
    parameter int STORE_DEPTH = 8,
    parameter int ACK_WAIT_CYC = LIR_ACK_WAIT_CYC,
    parameter int LF_HOLD_CYC = LIR_LF_HOLD_CYC,
    parameter bit KEEP_UNREG = 1'b0,
    parameter bit FULL_RECORD = 1'b0,
    parameter bit RX_SUPPORTED = 1'b1,
    parameter logic [7:0] RX_SPEC_FORMAT = 8'h00
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [23:0] own_id,
    input wire logic [63:0] port_name,
    input wire logic [63:0] node_name,
    input wire logic cond_valid,
    input wire logic cond_code_defined,
    input wire logic [7:0] cond_code,
    input wire logic [7:0] cond_qualifier,
    output logic cond_ready,
    input wire logic link_fail,
    input wire logic [LIR_NREG-1:0] reg_valid,
    input wire logic [LIR_NREG-1:0] reg_always,
    input wire logic [LIR_NREG*24-1:0] reg_ids,
    output logic dereg_valid,
    output logic [1:0] dereg_index,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [31:0] tx_data,
    output logic tx_last,
    output logic [23:0] tx_sid,
    output logic [23:0] tx_did,
    output logic tx_port,
    input wire logic rep_valid,
    input wire logic rep_accept,
    input wire logic [23:0] rep_sid,
    input wire logic req_valid,
    input wire logic [23:0] req_sid,
    input wire logic [7:0] req_format,
    output logic req_ready,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [23:0] rsp_did,
    output logic rsp_accept,
    output logic [7:0] rsp_reason
);
    localparam int NW = FULL_RECORD ? LIR_WORDS_FULL : LIR_WORDS_SHORT;
    localparam logic [7:0] COMMON_LEN = FULL_RECORD ? LIR_COMMON_FULL : LIR_COMMON_SHORT;

    // ------------------------------------------------------------
    // incident recognition
    // ------------------------------------------------------------
    logic lf_fire;
    logic [31:0] tid_reg;
    logic [LIR_REC_W-1:0] new_rec;
    wire any_reg = |reg_valid;
    wire cond_take = cond_valid && !lf_fire;
    wire incident = lf_fire || (cond_take && cond_code_defined);
    wire gen_rec = incident && (any_reg || KEEP_UNREG);
    assign cond_ready = !lf_fire;
    assign new_rec = lf_fire ? {8'h00, LIR_LF_CODE, tid_reg} :
                               {cond_qualifier, cond_code, tid_reg};

    // failure must persist for the hold period, fires once per outage
    lir_timer #(.COUNT(LF_HOLD_CYC)) u_lf_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(link_fail),
        .expired(lf_fire)
    );

    // transaction id counts generated records
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) tid_reg <= LIR_TID_RESET;
        else if (gen_rec) tid_reg <= tid_reg + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // record store
    // ------------------------------------------------------------
    logic [LIR_REC_W-1:0] head_rec;
    logic st_empty;
    logic st_full;
    lir_state_t state_reg;
    wire pop = (state_reg == LIR_IDLE) && !st_empty;

    lir_store #(.WIDTH(LIR_REC_W), .DEPTH(STORE_DEPTH)) u_store (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .push(gen_rec),
        .push_data(new_rec),
        .pop(pop),
        .head_data(head_rec),
        .empty(st_empty),
        .full(st_full)
    );

    // ------------------------------------------------------------
    // recipient selection
    // ------------------------------------------------------------
    logic [LIR_REC_W-1:0] cur_reg;
    logic [LIR_NREG-1:0] tried_reg;
    logic always_ph_reg;
    logic any_ok_reg;
    logic alt_reg;
    logic [1:0] idx_reg;
    logic [23:0] did_reg;
    logic [4:0] wcnt_reg;
    logic [31:0] data_reg;
    logic [1:0] pick;
    wire [LIR_NREG-1:0] cand = reg_valid & ~tried_reg &
                               (always_ph_reg ? reg_always : ~reg_always);
    wire have_cand = |cand;
    wire last_word = (wcnt_reg == 5'(NW - 1));
    wire tx_fire = tx_valid && tx_ready;
    wire waiting = (state_reg == LIR_WAIT);
    wire ack_match = waiting && rep_valid && (rep_sid == did_reg);
    wire ack_ok = ack_match && rep_accept;
    logic ack_tout;
    wire fail = waiting && ((ack_match && !rep_accept) || ack_tout);

    // lowest pending candidate first
    always_comb begin
        pick = 2'd0;
        for (int i = LIR_NREG - 1; i >= 0; i--) begin
            if (cand[i]) pick = 2'(i);
        end
    end

    // reply window opens once the last word has gone
    lir_timer #(.COUNT(ACK_WAIT_CYC)) u_ack_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(waiting),
        .expired(ack_tout)
    );

    // ------------------------------------------------------------
    // payload words
    // ------------------------------------------------------------
    function automatic logic [31:0] pay_word(input logic [4:0] w,
                                             input logic [LIR_REC_W-1:0] rec);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (w == 5'd0) r = {LIR_CMD_CODE, 24'h00_0000};
        else if (w == 5'd1) r = {LIR_FORMAT_COMMON, COMMON_LEN,
                                 LIR_DESC_LEN, LIR_SPEC_LEN};
        else if (w == 5'd2) r = port_name[63:32];
        else if (w == 5'd3) r = port_name[31:0];
        else if (w == 5'd4) r = node_name[63:32];
        else if (w == 5'd5) r = node_name[31:0];
        else if (w == 5'(NW - 1)) r = {rec[47:40], rec[39:32], 16'h0000};
        else if (FULL_RECORD && w == 5'(LIR_TID_WORD)) r = rec[31:0];
        return r;
    endfunction

    // ------------------------------------------------------------
    // delivery sequencer
    // ------------------------------------------------------------
    // idle: pop, pick: choose recipient, send: words, wait: reply
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= LIR_IDLE;
            cur_reg <= '0;
            tried_reg <= '0;
            always_ph_reg <= 1'b1;
            any_ok_reg <= 1'b0;
            alt_reg <= 1'b0;
            idx_reg <= 2'd0;
            did_reg <= 24'h00_0000;
            wcnt_reg <= 5'd0;
            data_reg <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                LIR_IDLE: begin
                    if (!st_empty) begin
                        cur_reg <= head_rec;
                        tried_reg <= '0;
                        always_ph_reg <= 1'b1;
                        any_ok_reg <= 1'b0;
                        alt_reg <= 1'b0;
                        state_reg <= LIR_PICK;
                    end
                end
                LIR_PICK: begin
                    if (have_cand) begin
                        idx_reg <= pick;
                        did_reg <= reg_ids[pick*24 +: 24];
                        wcnt_reg <= 5'd0;
                        data_reg <= pay_word(5'd0, cur_reg);
                        state_reg <= LIR_SEND;
                    end else if (always_ph_reg) begin
                        if (any_ok_reg) begin
                            state_reg <= LIR_IDLE;
                        end else begin
                            always_ph_reg <= 1'b0;
                            tried_reg <= '0;
                        end
                    end else if (!alt_reg) begin
                        alt_reg <= 1'b1;
                        always_ph_reg <= 1'b1;
                        tried_reg <= '0;
                    end else begin
                        state_reg <= LIR_IDLE;
                    end
                end
                LIR_SEND: begin
                    if (tx_fire) begin
                        wcnt_reg <= wcnt_reg + 5'd1;
                        data_reg <= pay_word(wcnt_reg + 5'd1, cur_reg);
                        if (last_word) state_reg <= LIR_WAIT;
                    end
                end
                LIR_WAIT: begin
                    if (ack_ok) begin
                        tried_reg[idx_reg] <= 1'b1;
                        any_ok_reg <= 1'b1;
                        state_reg <= always_ph_reg ? LIR_PICK : LIR_IDLE;
                    end else if (fail) begin
                        tried_reg[idx_reg] <= 1'b1;
                        state_reg <= LIR_PICK;
                    end
                end
            endcase
        end
    end

    assign tx_valid = (state_reg == LIR_SEND);
    assign tx_data = data_reg;
    assign tx_last = tx_valid && last_word;
    assign tx_sid = own_id;
    assign tx_did = did_reg;
    assign tx_port = alt_reg;
    assign dereg_valid = fail;
    assign dereg_index = idx_reg;

    // ------------------------------------------------------------
    // answers to incoming requests
    // ------------------------------------------------------------
    logic rsp_valid_reg;
    logic rsp_acc_reg;
    logic [7:0] rsp_rsn_reg;
    logic [23:0] rsp_did_reg;
    wire fmt_ok = (req_format == LIR_FORMAT_COMMON) || (req_format == RX_SPEC_FORMAT);
    wire req_take = req_valid && req_ready;
    assign req_ready = !rsp_valid_reg;

    // one reply held until taken
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_acc_reg <= LIR_RSP_RJT;
            rsp_rsn_reg <= 8'h00;
            rsp_did_reg <= 24'h00_0000;
        end else if (req_take) begin
            rsp_valid_reg <= 1'b1;
            rsp_did_reg <= req_sid;
            if (!RX_SUPPORTED) begin
                rsp_acc_reg <= LIR_RSP_RJT;
                rsp_rsn_reg <= LIR_RSN_NOT_SUPP;
            end else if (!fmt_ok) begin
                rsp_acc_reg <= LIR_RSP_RJT;
                rsp_rsn_reg <= LIR_RSN_UNABLE;
            end else begin
                rsp_acc_reg <= LIR_RSP_ACC;
                rsp_rsn_reg <= 8'h00;
            end
        end else if (rsp_ready) begin
            rsp_valid_reg <= 1'b0;
        end
    end
    assign rsp_valid = rsp_valid_reg;
    assign rsp_accept = rsp_acc_reg;
    assign rsp_reason = rsp_rsn_reg;
    assign rsp_did = rsp_did_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_req_in;
        req_valid && req_ready;
    endsequence
    sequence s_last_out;
        tx_valid && tx_ready && tx_last;
    endsequence

    a_accept_reply: assert property (
        s_req_in and (RX_SUPPORTED && fmt_ok) |=> rsp_valid && rsp_accept)
        else $error("supported request not accepted");
    a_unsup_reject: assert property (
        s_req_in and !RX_SUPPORTED |=> rsp_valid && !rsp_accept &&
        rsp_reason == LIR_RSN_NOT_SUPP)
        else $error("unsupported request not rejected");
    a_format_reject: assert property (
        s_req_in and (RX_SUPPORTED && !fmt_ok) |=> !rsp_accept &&
        rsp_reason == LIR_RSN_UNABLE)
        else $error("bad format not rejected");
    a_first_word: assert property (
        tx_valid && wcnt_reg == 5'd0 |-> tx_data == 32'h7900_0000)
        else $error("first payload word wrong");
    a_length_word: assert property (
        tx_valid && wcnt_reg == 5'd1 |-> tx_data[15:8] == 8'h04 &&
        tx_data[7:0] == 8'h00 && tx_data[31:24] == 8'h00)
        else $error("length word wrong");
    a_wait_after: assert property (
        s_last_out |=> waiting ##1 !tx_valid)
        else $error("no wait after request");
    a_tid_step: assert property (
        gen_rec |=> tid_reg == $past(tid_reg) + 32'h0000_0001)
        else $error("transaction id not stepped");
    a_dst_addr: assert property (
        tx_valid |-> tx_did == reg_ids[idx_reg*24 +: 24] && tx_sid == own_id)
        else $error("request addressing wrong");
    a_always_first: assert property (
        state_reg == LIR_PICK && always_ph_reg && have_cand |=>
        state_reg == LIR_SEND && reg_always[idx_reg])
        else $error("always registrant skipped");
    a_fail_dereg: assert property (
        waiting && ack_tout |-> dereg_valid ##1 state_reg == LIR_PICK)
        else $error("timeout not flagged");
endmodule
`default_nettype wire

// ===== logic/lir_pkg.sv
/*
  Shared constants for the link incident reporter: payload layout,
  reply codes, record layout and timing counts.
  Assumes a single 200 MHz core clock and framing done outside.
*/
// How it works
// - Supported acceptable request gets payloadless accept
// - Unsupported request rejected: command not supported
// - Unacceptable record type rejected: unable to perform
// - Condition with defined code is an incident
// - Registered recipient present: create and report record
// - Link failure reported only after hold period
// - Exactly one record per incident
// - Full store drops oldest, keeps newest
// - Record freed from store when its delivery starts
// - Recipients chosen per record format; here chosen by always flag only, with one format fixed at build
// - Send first to every always registrant
// - Else send to one conditional registrant
// - Failed conditional delivery tries another registrant
// - Success only with accept within twice timeout
// - Failed registrant may be deregistered
// - Failed delivery retried via other port
// - Unregistered records kept or dropped: build option
// - One request then one accept or reject
// - Source names reporter, destination names registrant
// - First word is 79h then three zeros
// - Length word, common record, descriptor, specific
// - Descriptor length 4; common 16 or 64
// - Specific length zero with zero format
package lir_pkg;
    // ------------------------------------------------------------
    // payload layout
    // ------------------------------------------------------------
    localparam logic [7:0] LIR_CMD_CODE = 8'h79;
    localparam logic [7:0] LIR_DESC_LEN = 8'h04;
    localparam logic [7:0] LIR_COMMON_SHORT = 8'h10;
    localparam logic [7:0] LIR_COMMON_FULL = 8'h40;
    localparam logic [7:0] LIR_SPEC_LEN = 8'h00;
    localparam logic [7:0] LIR_FORMAT_COMMON = 8'h00;
    localparam int LIR_WORDS_SHORT = 7;
    localparam int LIR_WORDS_FULL = 19;
    localparam int LIR_TID_WORD = 14;
    // ------------------------------------------------------------
    // reply and incident codes (plain defaults)
    // ------------------------------------------------------------
    localparam logic LIR_RSP_ACC = 1'b1;
    localparam logic LIR_RSP_RJT = 1'b0;
    localparam logic [7:0] LIR_RSN_NOT_SUPP = 8'h0B;
    localparam logic [7:0] LIR_RSN_UNABLE = 8'h09;
    localparam logic [7:0] LIR_LF_CODE = 8'h01;
    // ------------------------------------------------------------
    // records, registrants, timing
    // ------------------------------------------------------------
    localparam int LIR_REC_W = 48;
    localparam int LIR_NREG = 4;
    localparam logic [31:0] LIR_TID_RESET = 32'h0000_0001;
    localparam int LIR_CLK_MHZ = 200;
    localparam int LIR_RA_TOV_MS = 10;
    localparam int LIR_LF_HOLD_MS = 100;
    localparam int LIR_ACK_WAIT_CYC = 2 * LIR_RA_TOV_MS * LIR_CLK_MHZ * 1000;
    localparam int LIR_LF_HOLD_CYC = LIR_LF_HOLD_MS * LIR_CLK_MHZ * 1000;
    typedef enum logic [1:0] {LIR_IDLE, LIR_PICK, LIR_SEND, LIR_WAIT} lir_state_t;
endpackage

// ===== logic/lir_timer.sv
/*
  Run-while-high cycle timer: one pulse when the run level has lasted
  COUNT cycles, then quiet until run drops.
  Assumes run is synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lir_timer #(
    parameter int COUNT = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic run,
    output logic expired
);
    logic [31:0] cnt_reg;
    logic done_reg;
    wire hit = run && !done_reg && (cnt_reg == 32'(COUNT - 1));

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // count while run, hold after firing
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
        end else if (!done_reg) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
            done_reg <= hit;
        end
    end
    assign expired = hit;
endmodule
`default_nettype wire

// ===== logic/lir_store.sv
/*
  Circular record store, oldest at the head. A push into a full store
  overwrites the oldest entry.
  Assumes pop is only asserted while not empty.
*/
`timescale 1ns/1ps
`default_nettype none
module lir_store #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head_data,
    output logic empty,
    output logic full
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] head_reg;
    logic [AW-1:0] tail_reg;
    logic [AW:0] cnt_reg;
    wire overwrite = push && full && !pop;
    wire adv_head = pop || overwrite;
    wire [AW-1:0] head_inc = (head_reg == AW'(DEPTH - 1)) ? '0 : head_reg + 1'b1;
    wire [AW-1:0] tail_inc = (tail_reg == AW'(DEPTH - 1)) ? '0 : tail_reg + 1'b1;

    assign empty = (cnt_reg == '0);
    assign full = (cnt_reg == (AW+1)'(DEPTH));
    assign head_data = mem_reg[head_reg];

    // ------------------------------------------------------------
    // pointers and storage
    // ------------------------------------------------------------
    // full push drops the oldest entry
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            head_reg <= '0;
            tail_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) tail_reg <= tail_inc;
            if (adv_head) head_reg <= head_inc;
            if (push && !pop && !full) cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
        end
    end
    // data array, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) mem_reg[tail_reg] <= push_data;
    end
endmodule
`default_nettype wire

// ===== tb/lir_far_port.sv
/*
  Remote port model: takes request words, replies once per request.
  Assumes the reporter drives tx_* and samples rep_* on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lir_far_port (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic stall,
    input wire logic [23:0] reject_id,
    input wire logic [3:0] delay,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic [23:0] tx_did,
    output logic tx_ready,
    output logic rep_valid,
    output logic rep_accept,
    output logic [23:0] rep_sid
);
    int cnt;
    logic [23:0] did_reg;
    // words are taken unless stalled
    assign tx_ready = !stall && arst_n;
    // one accept or reject per request, a few cycles after its last word
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            did_reg <= 24'h000000;
            rep_valid <= 1'b0;
            rep_accept <= 1'b0;
            rep_sid <= 24'hFFFFFF;
        end else begin
            rep_valid <= 1'b0;
            rep_accept <= ~rep_accept; // idle reply lines keep moving
            rep_sid <= ~rep_sid;
            if (tx_valid && tx_ready && tx_last) begin
                cnt <= delay + 1;
                did_reg <= tx_did;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    rep_valid <= 1'b1;
                    rep_accept <= (did_reg != reject_id);
                    rep_sid <= did_reg;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the reporter: incidents, delivery, store
  overflow and incoming requests. Assumes shortened hold and wait counts.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lir_pkg::*;
    logic core_clk, arst_n, cond_valid, cond_code_defined, cond_ready, link_fail;
    logic [23:0] own_id, rep_sid, req_sid, rsp_did, tx_sid, tx_did, reject_id;
    logic [63:0] port_name, node_name;
    logic [7:0] cond_code, cond_qualifier, req_format, rsp_reason;
    logic [3:0] reg_valid, reg_always, delay;
    logic [95:0] reg_ids;
    logic dereg_valid, tx_valid, tx_ready, tx_last, tx_port, rep_valid, rep_accept;
    logic req_valid, req_ready, rsp_valid, rsp_ready, rsp_accept, stall;
    logic [1:0] dereg_index, last_dereg;
    logic [31:0] tx_data, rng;
    logic [31:0] words[$];
    logic [23:0] dids[$];
    int n_mismatch, tests_run, n_dereg;
    lir_reporter #(.ACK_WAIT_CYC(50), .LF_HOLD_CYC(20)) u_dut (.core_clk(core_clk),
        .arst_n(arst_n), .own_id(own_id), .port_name(port_name), .node_name(node_name),
        .cond_valid(cond_valid), .cond_code_defined(cond_code_defined), .cond_code(cond_code),
        .cond_qualifier(cond_qualifier), .cond_ready(cond_ready), .link_fail(link_fail),
        .reg_valid(reg_valid), .reg_always(reg_always), .reg_ids(reg_ids),
        .dereg_valid(dereg_valid), .dereg_index(dereg_index), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_sid(tx_sid),
        .tx_did(tx_did), .tx_port(tx_port), .rep_valid(rep_valid), .rep_accept(rep_accept),
        .rep_sid(rep_sid), .req_valid(req_valid), .req_sid(req_sid), .req_format(req_format),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_did(rsp_did), .rsp_accept(rsp_accept), .rsp_reason(rsp_reason));
    lir_far_port u_far (.core_clk(core_clk), .arst_n(arst_n), .stall(stall),
        .reject_id(reject_id), .delay(delay), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_did(tx_did), .tx_ready(tx_ready), .rep_valid(rep_valid),
        .rep_accept(rep_accept), .rep_sid(rep_sid));
    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // capture every word taken, with its addressing
    always @(posedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            words.push_back(tx_data);
            dids.push_back(tx_did);
            chk("tx_sid", {8'h00, own_id}, {8'h00, tx_sid});
            chk("tx_port", 0, tx_port);
        end
        if (dereg_valid === 1'b1) begin
            n_dereg++;
            last_dereg = dereg_index;
        end
    end
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // expected payload word of a names-only record
    function automatic logic [31:0] exp_word(input int i, input logic [7:0] q,
                                             input logic [7:0] c);
        case (i)
            0: exp_word = 32'h7900_0000;
            1: exp_word = 32'h0010_0400;
            2: exp_word = port_name[63:32];
            3: exp_word = port_name[31:0];
            4: exp_word = node_name[63:32];
            5: exp_word = node_name[31:0];
            default: exp_word = {q, c, 16'h0000};
        endcase
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_words(input int n);
        for (int k = 0; k < 3000; k++) begin
            @(negedge core_clk);
            if (words.size() >= n) return;
        end
        chk("word count", n, words.size());
        end_sim();
    endtask
    task automatic incident(input logic def, input logic [7:0] q, input logic [7:0] c);
        @(posedge core_clk);
        cond_valid <= 1'b1;
        cond_code_defined <= def;
        cond_qualifier <= q;
        cond_code <= c;
        @(posedge core_clk);
        cond_valid <= 1'b0;
    endtask
    // compare n words of one record and its destination
    task automatic chk_rec(input int b, input int n, input logic [7:0] q,
                           input logic [7:0] c, input logic [23:0] d);
        for (int i = 0; i < n; i++) chk("payload", exp_word(i, q, c), words[b+i]);
        chk("tx_did", {8'h00, d}, {8'h00, dids[b]});
    endtask
    initial begin
        logic [7:0] q, c, f;
        logic [23:0] s;
        rng = 68397;
        {cond_valid, cond_code_defined, link_fail, req_valid, rsp_ready, stall} = '0;
        own_id = rnd();
        port_name = {rnd(), rnd()};
        node_name = {rnd(), rnd()};
        {cond_code, cond_qualifier, req_format, req_sid} = '0;
        reg_valid = 4'h1;
        reg_always = 4'h1;
        reg_ids = {rnd(), rnd(), rnd()} & {4{24'h7FFFFF}};
        reject_id = 24'hFFFFFF;
        delay = 4'h3;
        arst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        chk("tx_valid in reset", 0, tx_valid);
        chk("req_ready in reset", 1, req_ready);
        arst_n <= 1'b1;
        // one always registrant accepts: one request, once
        q = rnd();
        c = rnd();
        incident(1'b1, q, c);
        wait_words(7);
        repeat (80) @(negedge core_clk);
        chk("one request", 7, words.size());
        chk_rec(0, 7, q, c, reg_ids[23:0]);
        // undefined code makes no record
        incident(1'b0, q, c);
        repeat (40) @(negedge core_clk);
        chk("undefined code", 7, words.size());
        // always registrant rejects, conditional registrant takes it
        reg_valid <= 4'h3;
        reject_id <= reg_ids[23:0];
        incident(1'b1, q, c);
        wait_words(21);
        repeat (80) @(negedge core_clk);
        chk("fallback count", 21, words.size());
        chk_rec(7, 7, q, c, reg_ids[23:0]);
        chk_rec(14, 7, q, c, reg_ids[47:24]);
        chk("dereg count", 1, n_dereg);
        chk("dereg index", 0, last_dereg);
        // short link failure is not reported, a lasting one is
        reject_id <= 24'hFFFFFF;
        link_fail <= 1'b1;
        repeat (10) @(posedge core_clk);
        link_fail <= 1'b0;
        repeat (40) @(negedge core_clk);
        chk("short failure", 21, words.size());
        @(posedge core_clk);
        link_fail <= 1'b1;
        repeat (40) @(posedge core_clk);
        link_fail <= 1'b0;
        wait_words(28);
        chk_rec(21, 6, q, c, reg_ids[23:0]);
        chk("failure code", LIR_LF_CODE, words[27][23:16]);
        // ten incidents while stalled: the oldest stored one is lost
        repeat (60) @(posedge core_clk);
        stall <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            incident(1'b1, k, 8'h33);
            @(posedge core_clk);
        end
        stall <= 1'b0;
        wait_words(91);
        for (int k = 0; k < 9; k++) begin
            chk("store order", exp_word(6, (k == 0) ? 0 : k + 1, 8'h33), words[34+7*k]);
        end
        // incoming requests: accept plain format, reject others
        for (int k = 0; k < 6; k++) begin
            f = k[0] ? (rnd() | 8'h01) : 8'h00;
            s = rnd();
            @(posedge core_clk);
            req_valid <= 1'b1;
            req_format <= f;
            req_sid <= s;
            @(negedge core_clk);
            chk("req_ready", 1, req_ready);
            @(posedge core_clk);
            req_valid <= 1'b0;
            repeat (3) @(negedge core_clk);
            chk("rsp_valid stands", 1, rsp_valid);
            chk("rsp_did", {8'h00, s}, {8'h00, rsp_did});
            chk("rsp_accept", (f == 0), rsp_accept);
            chk("rsp_reason", (f == 0) ? 8'h00 : 8'h09, rsp_reason);
            @(posedge core_clk);
            rsp_ready <= 1'b1;
            @(posedge core_clk);
            rsp_ready <= 1'b0;
        end
        end_sim();
    end
endmodule
`default_nettype wire
